/* inc/phy_status_pkg.sv */
// ---------------------------------------------------------------------------
// status summary register map and field layout
// ---------------------------------------------------------------------------
package phy_status_pkg;

  // register addresses on the management port (5-bit register space)
  localparam logic [4:0] ADDR_NEG_EXPANSION = 5'h06; // negotiation_expansion_reg
  localparam logic [4:0] ADDR_STATUS_SUMMARY = 5'h10; // phy_status_summary
  localparam logic [4:0] ADDR_INT_STATUS = 5'h12; // interrupt_status_event_reg
  localparam logic [4:0] ADDR_FALSE_CARRIER = 5'h14; // false_carrier_counter_reg
  localparam logic [4:0] ADDR_RX_ERROR = 5'h15; // receive_error_counter_reg
  localparam logic [4:0] ADDR_TEN_STATUS = 5'h1a; // ten_mbps_status_control_reg

  // field positions inside phy_status_summary
  localparam int BIT_RESERVED = 15;
  localparam int BIT_CROSSOVER = 14;
  localparam int BIT_RX_ERROR = 13;
  localparam int BIT_POLARITY = 12;
  localparam int BIT_SIGNAL_DETECT = 10;
  localparam int BIT_FALSE_CARRIER = 11;
  localparam int BIT_DESCR_LOCK = 9;
  localparam int BIT_PAGE_RX = 8;
  localparam int BIT_INT_PENDING = 7;

  // reset values
  localparam logic [15:0] SUMMARY_RESET = 16'h0000;
  localparam logic LATCH_LOW_RESET = 1'b1; // latch-low bits read 0 until first read

  // status and event inputs from the rest of the port, same clock domain
  typedef struct packed {
    logic mdix_swapped; // crossover state chosen by the algorithm
    logic auto_crossover_enable; // from phy_control_reg
    logic crossover_force; // from phy_control_reg
    logic rx_error_event; // one-cycle receive error
    logic polarity_inverted; // 10 Mb/s polarity detector level
    logic false_carrier_event; // one-cycle false carrier
    logic raw_signal_detect; // 100 Mb/s raw signal detect level
    logic descrambler_lock; // 100 Mb/s descrambler lock level
    logic detect_qualify_en; // register 16h bit 8
    logic page_received_event; // one-cycle page received
    logic interrupt_event; // one-cycle enabled interrupt event
  } status_in_t;

  // management read request
  typedef struct packed {
    logic strobe; // one-cycle read request
    logic [4:0] addr; // register address
  } mgmt_read_t;

endpackage : phy_status_pkg

/* logic/phy_status_summary_upper.sv */
`timescale 1ns/1ps
module phy_status_summary_upper
  import phy_status_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // management register port
  input wire mgmt_read_t rd_i,
  input wire logic wr_strobe_i,
  input wire logic [15:0] wr_data_i,
  output logic [15:0] rd_data_o,
  output logic rd_valid_o,
  // status from the rest of the port
  input wire status_in_t st_i,
  // summary view and interrupt line to the rest of the chip
  output logic [15:0] summary_o,
  output logic int_pending_o
);

  // ---------------------------------------------------------------------------
  // read decode
  // ---------------------------------------------------------------------------
  wire rd_summary = rd_i.strobe && (rd_i.addr == ADDR_STATUS_SUMMARY); // summary read
  wire rd_rx_err = rd_i.strobe && (rd_i.addr == ADDR_RX_ERROR); // receive error counter read
  wire rd_fcar = rd_i.strobe && (rd_i.addr == ADDR_FALSE_CARRIER); // false carrier counter read
  wire rd_ten = rd_i.strobe && (rd_i.addr == ADDR_TEN_STATUS); // 10 Mb/s status read
  wire rd_neg = rd_i.strobe && (rd_i.addr == ADDR_NEG_EXPANSION); // expansion read
  wire rd_int = rd_i.strobe && (rd_i.addr == ADDR_INT_STATUS); // interrupt status read
  // the register is read only, so writes, bit 15 included, change nothing
  wire wr_unused = wr_strobe_i & (|wr_data_i);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  logic crossover_ff; // reported crossover state
  logic rx_err_ff; // sticky receive error
  logic polarity_ff; // sticky inverted polarity
  logic fcar_ff; // sticky false carrier
  logic detect_low_ff; // signal detect dropped since last summary read
  logic lock_low_ff; // lock dropped since last summary read
  logic page_ff; // sticky page received
  logic int_ff; // interrupt pending
  logic [15:0] rd_data_ff;
  logic rd_valid_ff;
  logic [15:0] summary_ff;

  // ---------------------------------------------------------------------------
  // next values
  // ---------------------------------------------------------------------------
  // enabled: track the algorithm each cycle; disabled: the force setting decides
  wire nxt_crossover = st_i.auto_crossover_enable ? st_i.mdix_swapped
                                                  : st_i.crossover_force;
  // every sticky flag: a set in the clearing cycle wins over the clear
  wire nxt_rx_err = st_i.rx_error_event | (rx_err_ff & ~rd_rx_err);
  wire nxt_polarity = st_i.polarity_inverted | (polarity_ff & ~rd_ten);
  wire nxt_fcar = st_i.false_carrier_event | (fcar_ff & ~rd_fcar);
  wire nxt_page = st_i.page_received_event | (page_ff & ~rd_neg);
  wire nxt_int = st_i.interrupt_event | (int_ff & ~rd_int);
  // qualified detect: lock gates raw detect only when 16h bit 8 is set
  wire detect_live = st_i.raw_signal_detect & (st_i.descrambler_lock | ~st_i.detect_qualify_en);
  // latch-low: a low level re-arms the hold even in the read cycle
  wire nxt_detect_low = ~detect_live | (detect_low_ff & ~rd_summary);
  wire nxt_lock_low = ~st_i.descrambler_lock | (lock_low_ff & ~rd_summary);

  // assembled summary, bits 6..0 belong to another block and read zero here
  logic [15:0] nxt_summary;
  always_comb begin
    nxt_summary = SUMMARY_RESET;
    nxt_summary[BIT_RESERVED] = 1'b0;
    nxt_summary[BIT_CROSSOVER] = crossover_ff;
    nxt_summary[BIT_RX_ERROR] = rx_err_ff;
    nxt_summary[BIT_POLARITY] = polarity_ff;
    nxt_summary[BIT_FALSE_CARRIER] = fcar_ff;
    nxt_summary[BIT_SIGNAL_DETECT] = detect_live & ~detect_low_ff;
    nxt_summary[BIT_DESCR_LOCK] = st_i.descrambler_lock & ~lock_low_ff;
    nxt_summary[BIT_PAGE_RX] = page_ff;
    nxt_summary[BIT_INT_PENDING] = int_ff;
  end

  // read data is the summary seen before this read's clears take effect
  wire [15:0] nxt_rd_data = rd_summary ? nxt_summary : 16'h0000;

  // ---------------------------------------------------------------------------
  // flags
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      crossover_ff <= 1'b0;
      rx_err_ff <= 1'b0;
      polarity_ff <= 1'b0;
      fcar_ff <= 1'b0;
      page_ff <= 1'b0;
      int_ff <= 1'b0;
      detect_low_ff <= LATCH_LOW_RESET;
      lock_low_ff <= LATCH_LOW_RESET;
    end else begin
      crossover_ff <= nxt_crossover;
      rx_err_ff <= nxt_rx_err;
      polarity_ff <= nxt_polarity;
      fcar_ff <= nxt_fcar;
      page_ff <= nxt_page;
      int_ff <= nxt_int;
      detect_low_ff <= nxt_detect_low;
      lock_low_ff <= nxt_lock_low;
    end
  end

  // ---------------------------------------------------------------------------
  // output registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_ff <= SUMMARY_RESET;
      rd_valid_ff <= 1'b0;
      summary_ff <= SUMMARY_RESET;
    end else begin
      rd_data_ff <= nxt_rd_data;
      rd_valid_ff <= rd_summary;
      summary_ff <= nxt_summary;
    end
  end

  assign rd_data_o = rd_data_ff;
  assign rd_valid_o = rd_valid_ff;
  assign summary_o = summary_ff;
  assign int_pending_o = int_ff;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  a_top_bit_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    !rd_data_o[BIT_RESERVED] && !summary_o[BIT_RESERVED])
    else $error("reserved bit 15 read as one");

  a_cross_track: assert property (@(posedge clk_i) disable iff (rst_i)
    st_i.auto_crossover_enable ##1 1'b1 |-> ##1 summary_o[BIT_CROSSOVER] == $past(st_i.mdix_swapped, 2))
    else $error("crossover bit did not track the algorithm");

  a_rx_err_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    st_i.rx_error_event |=> rx_err_ff ##1 summary_o[BIT_RX_ERROR])
    else $error("receive error not latched");

  a_rx_err_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_rx_err && !st_i.rx_error_event |=> !rx_err_ff)
    else $error("receive error not cleared by counter read");

  a_pol_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    polarity_ff && !rd_ten |=> polarity_ff)
    else $error("polarity flag lost without its register read");

  a_fcar_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    st_i.false_carrier_event |=> fcar_ff)
    else $error("false carrier not latched");

  a_detect_qualify: assert property (@(posedge clk_i) disable iff (rst_i)
    st_i.detect_qualify_en && !st_i.descrambler_lock |=> !summary_o[BIT_SIGNAL_DETECT])
    else $error("signal detect shown without lock while qualified");

  a_page_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    page_ff && rd_summary |=> page_ff)
    else $error("page flag cleared by a summary read");

  a_int_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    int_pending_o && rd_int && !st_i.interrupt_event |=> !int_pending_o)
    else $error("interrupt not cleared by status read");

  a_lock_low: assert property (@(posedge clk_i) disable iff (rst_i)
    !st_i.descrambler_lock ##1 (!rd_summary)[*2] |=> !summary_o[BIT_DESCR_LOCK])
    else $error("lock bit rose before a summary read");

  a_reset_zero: assert property (@(posedge clk_i)
    $fell(rst_i) |-> summary_o[15:7] == 9'h000 && rd_data_o == 16'h0000)
    else $error("summary not zero after reset");

  // an event that meets its clearing read must survive, or the host misses it
  a_rx_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_rx_err && st_i.rx_error_event |=> rx_err_ff)
    else $error("receive error lost when set met its clear");

  a_pol_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    st_i.polarity_inverted |=> polarity_ff)
    else $error("inverted polarity not latched");

  a_fcar_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_fcar && !st_i.false_carrier_event |=> !fcar_ff)
    else $error("false carrier not cleared by counter read");

  a_page_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_neg && !st_i.page_received_event |=> !page_ff)
    else $error("page flag not cleared by expansion read");

  a_int_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    st_i.interrupt_event |=> int_pending_o)
    else $error("interrupt event not latched as pending");

  a_cross_force: assert property (@(posedge clk_i) disable iff (rst_i)
    !st_i.auto_crossover_enable ##1 1'b1 |-> ##1 summary_o[BIT_CROSSOVER] == $past(st_i.crossover_force, 2))
    else $error("crossover bit did not follow the force setting");

  a_detect_raw: assert property (@(posedge clk_i) disable iff (rst_i)
    !st_i.detect_qualify_en && !st_i.raw_signal_detect |=> !summary_o[BIT_SIGNAL_DETECT])
    else $error("signal detect shown without raw detect");

  a_lock_report: assert property (@(posedge clk_i) disable iff (rst_i)
    !st_i.descrambler_lock |=> !summary_o[BIT_DESCR_LOCK])
    else $error("lock bit shown while lock is low");

  a_read_pairs: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_summary |=> rd_valid_o && rd_data_o == summary_o)
    else $error("summary read answer differs from the live summary");

  a_write_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_unused && !rd_i.strobe |=> !rd_valid_o && rd_data_o == 16'h0000)
    else $error("write produced a read answer");

endmodule : phy_status_summary_upper

/* sim/mgmt_host.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// station manager model on the register port
// ---------------------------------------------------------------------------
module mgmt_host
  import phy_status_pkg::*;
(
  // clock
  input wire logic clk_i,
  // register port toward the device
  output mgmt_read_t rd_o,
  output logic wr_strobe_o,
  output logic [15:0] wr_data_o
);
  // idle bus at time zero
  initial begin
    rd_o = '0;
    wr_strobe_o = 1'b0;
    wr_data_o = 16'h0000;
  end
  // one-cycle read; address flips once released so stale values never match
  task automatic rd(input logic [4:0] a);
    @(posedge clk_i);
    rd_o <= '{strobe: 1'b1, addr: a};
    @(posedge clk_i);
    rd_o <= '{strobe: 1'b0, addr: ~a};
  endtask : rd
  // one-cycle write, same release habit
  task automatic wr(input logic [15:0] d);
    @(posedge clk_i);
    wr_strobe_o <= 1'b1;
    wr_data_o <= d;
    @(posedge clk_i);
    wr_strobe_o <= 1'b0;
    wr_data_o <= ~d;
  endtask : wr
endmodule : mgmt_host

/* sim/tb_phy_status_summary_upper.sv */
`timescale 1ns/1ps
module tb_phy_status_summary_upper;
  import phy_status_pkg::*;
  // ---------------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  mgmt_read_t rd;
  logic wr_s, rd_v, intp;
  logic [15:0] wr_d, rd_data, summ;
  status_in_t st = '0;
  logic [31:0] q[$]; // {mask, expected} per summary read
  logic [31:0] seed = 32'h7bd8;
  logic [31:0] e;
  int fail_count = 0;
  int check_count = 0;
  // clear-on-read addresses and the bit each one clears
  logic [4:0] ad[5] = '{ADDR_RX_ERROR, ADDR_FALSE_CARRIER, ADDR_TEN_STATUS, ADDR_NEG_EXPANSION, ADDR_INT_STATUS};
  logic [15:0] bt[5] = '{16'h2000, 16'h0800, 16'h1000, 16'h0100, 16'h0080};
  always #50 clk_i = ~clk_i;
  mgmt_host i_host (.clk_i(clk_i), .rd_o(rd), .wr_strobe_o(wr_s), .wr_data_o(wr_d));
  phy_status_summary_upper i_dut (.clk_i(clk_i), .rst_i(rst_i), .rd_i(rd), .wr_strobe_i(wr_s),
    .wr_data_i(wr_d), .rd_data_o(rd_data), .rd_valid_o(rd_v), .st_i(st), .summary_o(summ),
    .int_pending_o(intp));
  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] sn, input logic [15:0] m);
    check_count++;
    if ((sn & m) !== (ex & m)) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, ex & m, sn);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude
  // summary read with a noted expectation; answer must come within a few edges
  task automatic rs(input logic [15:0] ex, input logic [15:0] m = 16'hffff);
    int k;
    q.push_back({m, ex});
    i_host.rd(ADDR_STATUS_SUMMARY);
    k = 0;
    while (q.size() != 0 && k < 4) begin
      tick(1);
      k++;
    end
    if (q.size() != 0) begin
      fail_count++;
      conclude();
    end
  endtask : rs
  // one-cycle pulse on the chosen status fields
  task automatic pulse(input status_in_t m);
    @(posedge clk_i);
    st <= st | m;
    @(posedge clk_i);
    st <= st & ~m;
  endtask : pulse
  // monitor: every answered read consumes the oldest note, mid-low cycle
  always @(negedge clk_i) begin
    if (rd_v === 1'b1) begin
      e = q.pop_front();
      chk("rd_data", e[15:0], rd_data, e[31:16]);
      // the live summary is loaded on the same edge as the read data
      chk("summary", e[15:0], summ, e[31:16]);
    end
  end
  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    status_in_t m;
    logic [15:0] x;
    tick(6);
    rst_i <= 1'b0;
    m = '0;
    m.raw_signal_detect = 1'b1;
    m.descrambler_lock = 1'b1;
    m.detect_qualify_en = 1'b1;
    tick(1);
    st <= m;
    tick(3);
    rs(16'h0000);
    rs(16'h0600);
    i_host.wr(16'hffff);
    tick(2);
    rs(16'h0600);
    m = '0;
    m.rx_error_event = 1'b1;
    m.false_carrier_event = 1'b1;
    m.page_received_event = 1'b1;
    m.interrupt_event = 1'b1;
    m.polarity_inverted = 1'b1;
    pulse(m);
    tick(3);
    chk("int_pending", 16'h0001, {15'h0, intp}, 16'h0001);
    rs(16'h3f80);
    rs(16'h3f80);
    x = 16'h3f80;
    // each clear-on-read address drops only its own bit
    for (int i = 0; i < 5; i++) begin
      i_host.rd(ad[i]);
      tick(3);
      x &= ~bt[i];
      rs(x);
    end
    chk("int_pending", 16'h0000, {15'h0, intp}, 16'h0001);
    // a receive error in the very cycle of its clearing read survives
    m = '0;
    m.rx_error_event = 1'b1;
    fork
      i_host.rd(ADDR_RX_ERROR);
      pulse(m);
    join
    tick(3);
    rs(16'h2600);
    i_host.rd(ADDR_RX_ERROR);
    tick(3);
    rs(16'h0600);
    // random crossover settings: enable picks the algorithm, else force
    repeat (20) begin
      seed = xs(seed);
      m = st;
      m.mdix_swapped = seed[0];
      m.auto_crossover_enable = seed[1];
      m.crossover_force = seed[2];
      st <= m;
      tick(3);
      rs({1'b0, seed[1] ? seed[0] : seed[2], 14'h0600});
    end
    // lock drop is held low until a summary read releases it
    m = '0;
    m.raw_signal_detect = 1'b1;
    m.detect_qualify_en = 1'b1;
    st <= m;
    tick(3);
    m.descrambler_lock = 1'b1;
    st <= m;
    tick(3);
    rs(16'h0000);
    rs(16'h0600);
    m.raw_signal_detect = 1'b0;
    st <= m;
    tick(3);
    rs(16'h0200);
    m.raw_signal_detect = 1'b1;
    m.descrambler_lock = 1'b0;
    m.detect_qualify_en = 1'b0;
    st <= m;
    tick(3);
    rs(16'h0000);
    rs(16'h0400);
    // unqualified detect drops with raw detect alone
    m.raw_signal_detect = 1'b0;
    st <= m;
    tick(3);
    rs(16'h0000);
    conclude();
  end
endmodule : tb_phy_status_summary_upper
